/* File: scl_pkg.sv */
package scl_pkg;

   localparam int SCL_NPORT = 4;
   localparam int SCL_AW    = 8;

   // register byte offsets
   localparam logic [SCL_AW-1:0] SCL_STRAP_OFS  = 8'h00;
   localparam logic [SCL_AW-1:0] SCL_CTRL_OFS   = 8'h04;
   localparam logic [SCL_AW-1:0] SCL_RATE_OFS   = 8'h08;
   localparam logic [SCL_AW-1:0] SCL_STATUS_OFS = 8'h0c;

   // field positions
   localparam int SCL_OWNER_LSB      = 0;
   localparam int SCL_OWNER_W        = 2;
   localparam int SCL_POL_LSB        = 8;
   localparam int SCL_COMMIT_BIT     = 0;
   localparam int SCL_RATE_LSB       = 0;
   localparam int SCL_RATE_W         = 2;
   localparam int SCL_ST_SATA_LSB    = 0;
   localparam int SCL_ST_RUN_BIT     = 4;
   localparam int SCL_ST_SETTLE_BIT  = 5;
   localparam int SCL_ST_PIN_LSB     = 8;
   localparam int SCL_ST_PINMODE_LSB = 12;

   // reset values
   localparam logic [7:0] SCL_OWNER_RST = 8'h00;
   localparam logic [3:0] SCL_POL_RST   = 4'h0;
   localparam logic [7:0] SCL_RATE_RST  = 8'haa;

   // owner field encodings
   localparam logic [1:0] SCL_OWN_PCIE = 2'h0;
   localparam logic [1:0] SCL_OWN_SATA = 2'h1;
   localparam logic [1:0] SCL_OWN_RSVD = 2'h2;
   localparam logic [1:0] SCL_OWN_PIN  = 2'h3;

   // sata line rate encodings
   localparam logic [1:0] SCL_RATE_1G5 = 2'h0;
   localparam logic [1:0] SCL_RATE_3G  = 2'h1;
   localparam logic [1:0] SCL_RATE_6G  = 2'h2;

   // timing
   localparam int SCL_CLK_NS     = 8;
   localparam int SCL_SETTLE_NS  = 64;
   localparam int SCL_SETTLE_CYC = (SCL_SETTLE_NS + SCL_CLK_NS - 1) / SCL_CLK_NS;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } scl_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } scl_wb_rsp_type;

   typedef enum logic [2:0] {
      SCL_ST_WAIT   = 3'b001,
      SCL_ST_SETTLE = 3'b010,
      SCL_ST_RUN    = 3'b100
   } scl_state_type;

endpackage

/* File: scl_lane_select.sv */
`timescale 1ns/1ps
module scl_lane_select
   import scl_pkg::*;
#(
   parameter int DW         = 20,
   parameter int SETTLE_CYC = SCL_SETTLE_CYC
) (
   input  wire logic                             clk,
   input  wire logic                             sys_rst,
   input  wire scl_wb_req_type                   wb_req,
   output scl_wb_rsp_type                        wb_rsp,
   input  wire logic                             lane_select_in_2,
   input  wire logic                             lane_select_in_3,
   input  wire logic                             lane_select_in_4,
   input  wire logic                             lane_select_in_5,
   input  wire logic [SCL_NPORT-1:0][DW-1:0]     sata_tx_data,
   input  wire logic [SCL_NPORT-1:0][DW-1:0]     pcie_tx_data,
   input  wire logic [SCL_NPORT-1:0][DW-1:0]     lane_rx_data,
   output logic      [SCL_NPORT-1:0][DW-1:0]     lane_tx_data,
   output logic      [SCL_NPORT-1:0][DW-1:0]     sata_rx_data,
   output logic      [SCL_NPORT-1:0][DW-1:0]     pcie_rx_data,
   output logic      [SCL_NPORT-1:0]             sata_en,
   output logic      [SCL_NPORT-1:0]             pcie_en,
   output logic      [SCL_NPORT-1:0][1:0]        sata_rate
);

   ////////////////////////////////////////////////////////////////////////////
   generate
      if (DW < 1) begin : g_bad_dw
         $error("lane data width must be at least one");
      end
      if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
         $error("settle count must lie in 1..255");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic owner_is_sata(input logic [1:0] own, input logic pol, input logic pin);
      logic r;
      r = 1'b0;
      case (own)
         SCL_OWN_SATA: r = 1'b1;
         SCL_OWN_PIN:  r = pin ^ pol;
         default:      r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wdat,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [SCL_NPORT-1:0] sel_pin;
   logic [7:0]           owner_q;
   logic [3:0]           pol_q;
   logic [7:0]           rate_q;
   logic [SCL_NPORT-1:0] is_sata_q;
   logic [SCL_NPORT-1:0] is_sata_d;
   scl_state_type        state_q;
   logic [7:0]           settle_q;
   logic                 ack_q;
   logic [31:0]          rdat_q;
   logic                 wr_strobe;
   logic                 commit;
   logic [31:0]          strap_word;
   logic [31:0]          rate_word;
   logic [31:0]          status_word;
   logic [31:0]          strap_new;
   logic [31:0]          rate_new;
   logic [31:0]          ctrl_new;

   assign sel_pin = {lane_select_in_5, lane_select_in_4, lane_select_in_3, lane_select_in_2};

   // a write takes effect only at the edge where the master sees ack
   assign wr_strobe = wb_req.cyc & wb_req.stb & wb_req.we & ack_q;

   assign strap_word = {20'h0, pol_q, owner_q};
   assign rate_word  = {24'h0, rate_q};
   assign strap_new  = wb_merge(strap_word, wb_req.dat, wb_req.sel);
   assign rate_new   = wb_merge(rate_word, wb_req.dat, wb_req.sel);
   assign ctrl_new   = wb_merge(32'h0, wb_req.dat, wb_req.sel);
   assign commit     = wr_strobe && wb_req.adr == SCL_CTRL_OFS && ctrl_new[SCL_COMMIT_BIT] &&
                       state_q == SCL_ST_WAIT;

   ////////////////////////////////////////////////////////////////////////////
   // soft-strap image, writable only before commit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         owner_q <= SCL_OWNER_RST;
         pol_q   <= SCL_POL_RST;
      end else if (wr_strobe && wb_req.adr == SCL_STRAP_OFS && state_q == SCL_ST_WAIT) begin
         owner_q <= strap_new[SCL_OWNER_LSB +: 8];
         pol_q   <= strap_new[SCL_POL_LSB +: 4];
      end
   end

   // sata line rate limit, a reserved code leaves its field unchanged
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rate_q <= SCL_RATE_RST;
      end else if (wr_strobe && wb_req.adr == SCL_RATE_OFS) begin
         for (int i = 0; i < SCL_NPORT; i++) begin
            if (rate_new[SCL_RATE_LSB + i*SCL_RATE_W +: SCL_RATE_W] != 2'h3) begin
               rate_q[i*SCL_RATE_W +: SCL_RATE_W] <= rate_new[SCL_RATE_LSB + i*SCL_RATE_W +: SCL_RATE_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // owner resolution per combo port
   generate
      for (genvar i = 0; i < SCL_NPORT; i++) begin : g_resolve
         always_comb begin
            is_sata_d[i] = owner_is_sata(owner_q[i*SCL_OWNER_W +: SCL_OWNER_W], pol_q[i], sel_pin[i]);
         end
      end
   endgenerate

   // sampled once on commit, frozen until reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         is_sata_q <= '0;
      end else if (commit) begin
         is_sata_q <= is_sata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // controllers stay off until the assignment has settled
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q  <= SCL_ST_WAIT;
         settle_q <= 8'h0;
      end else begin
         unique case (state_q)
            SCL_ST_WAIT: begin
               if (commit) begin
                  state_q  <= SCL_ST_SETTLE;
                  settle_q <= 8'(SETTLE_CYC - 1);
               end
            end
            SCL_ST_SETTLE: begin
               if (settle_q == 8'h0) begin
                  state_q <= SCL_ST_RUN;
               end else begin
                  settle_q <= settle_q - 8'h1;
               end
            end
            SCL_ST_RUN: begin
               state_q <= SCL_ST_RUN;
            end
            default: begin
               state_q <= SCL_ST_WAIT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // controller enables and rate limits
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sata_en   <= '0;
         pcie_en   <= '0;
         sata_rate <= '0;
      end else begin
         for (int i = 0; i < SCL_NPORT; i++) begin
            sata_en[i]   <= state_q == SCL_ST_RUN && is_sata_q[i];
            pcie_en[i]   <= state_q == SCL_ST_RUN && !is_sata_q[i];
            sata_rate[i] <= rate_q[i*SCL_RATE_W +: SCL_RATE_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lane datapath: the non-owner sees idle zeros
   generate
      for (genvar i = 0; i < SCL_NPORT; i++) begin : g_lane
         always_ff @(posedge clk) begin
            if (sys_rst || state_q != SCL_ST_RUN) begin
               lane_tx_data[i] <= '0;
               sata_rx_data[i] <= '0;
               pcie_rx_data[i] <= '0;
            end else begin
               lane_tx_data[i] <= is_sata_q[i] ? sata_tx_data[i] : pcie_tx_data[i];
               sata_rx_data[i] <= is_sata_q[i] ? lane_rx_data[i] : '0;
               pcie_rx_data[i] <= is_sata_q[i] ? '0 : lane_rx_data[i];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after the request, unmapped reads zero
   always_comb begin
      status_word = 32'h0;
      status_word[SCL_ST_SATA_LSB +: SCL_NPORT]    = is_sata_q;
      status_word[SCL_ST_RUN_BIT]                  = state_q == SCL_ST_RUN;
      status_word[SCL_ST_SETTLE_BIT]               = state_q == SCL_ST_SETTLE;
      status_word[SCL_ST_PIN_LSB +: SCL_NPORT]     = sel_pin;
      for (int i = 0; i < SCL_NPORT; i++) begin
         status_word[SCL_ST_PINMODE_LSB + i] = owner_q[i*SCL_OWNER_W +: SCL_OWNER_W] == SCL_OWN_PIN;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         ack_q <= wb_req.cyc & wb_req.stb & ~ack_q;
         if (wb_req.cyc && wb_req.stb && !ack_q) begin
            unique case (wb_req.adr)
               SCL_STRAP_OFS:  rdat_q <= strap_word;
               SCL_RATE_OFS:   rdat_q <= rate_word;
               SCL_STATUS_OFS: rdat_q <= status_word;
               default:        rdat_q <= 32'h0;
            endcase
         end
      end
   end

   assign wb_rsp.ack = ack_q;
   assign wb_rsp.dat = rdat_q;

endmodule

/* File: scl_link_model.sv */
`timescale 1ns/1ps
module scl_link_model
   import scl_pkg::*;
#(
   parameter int DW = 20
) (
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   output logic      [SCL_NPORT-1:0][DW-1:0] lane_rx_data
);
   logic [DW-3:0] cnt_q;
   // a fresh word every cycle so a stale or swapped capture shows
   always_ff @(posedge clk) begin
      cnt_q <= sys_rst ? '0 : cnt_q + 1'b1;
      for (int i = 0; i < SCL_NPORT; i++) lane_rx_data[i] <= {cnt_q, 2'(i)};
   end
endmodule

/* File: scl_lane_select_props.sv */
`timescale 1ns/1ps
module scl_lane_select_props
   import scl_pkg::*;
#(
   parameter int DW = 20
) (
   input wire logic                         clk,
   input wire logic                         sys_rst,
   input wire scl_wb_req_type               wb_req,
   input wire scl_wb_rsp_type               wb_rsp,
   input wire logic [SCL_NPORT-1:0][DW-1:0] pcie_tx_data,
   input wire logic [SCL_NPORT-1:0][DW-1:0] lane_rx_data,
   input wire logic [SCL_NPORT-1:0][DW-1:0] lane_tx_data,
   input wire logic [SCL_NPORT-1:0][DW-1:0] sata_rx_data,
   input wire logic [SCL_NPORT-1:0][DW-1:0] pcie_rx_data,
   input wire logic [SCL_NPORT-1:0]         sata_en,
   input wire logic [SCL_NPORT-1:0]         pcie_en,
   input wire logic [SCL_NPORT-1:0][1:0]    sata_rate
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
   ack_answer_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack) else $error("no ack");
   owner_excl_a: assert property (!(sata_en & pcie_en)) else $error("two owners");
   owner_hold_a: assert property (|(sata_en | pcie_en) |=> $stable(sata_en) && $stable(pcie_en))
      else $error("owner changed");
   rx_sata_a: assert property (sata_en[0] && $past(sata_en[0]) |-> sata_rx_data[0] == $past(lane_rx_data[0]))
      else $error("sata rx wrong");
   rx_pcie_a: assert property (pcie_en[1] && $past(pcie_en[1]) |-> pcie_rx_data[1] == $past(lane_rx_data[1]))
      else $error("pcie rx wrong");
   rx_idle_a: assert property (pcie_en[2] |-> sata_rx_data[2] == '0) else $error("non-owner rx");
   tx_pcie_a: assert property (pcie_en[3] && $past(pcie_en[3]) |-> lane_tx_data[3] == $past(pcie_tx_data[3]))
      else $error("pcie tx wrong");
   rate_legal_a: assert property (sata_rate[0] != 2'h3 && sata_rate[1] != 2'h3 && sata_rate[2] != 2'h3
      && sata_rate[3] != 2'h3) else $error("bad rate");
   cover property (sata_en[0]);
   cover property (pcie_en[3]);
   cover property (wb_req.we && wb_rsp.ack);
endmodule
bind scl_lane_select scl_lane_select_props #(.DW(DW)) i_props (.*);

/* File: scl_lane_select_bench.sv */
`timescale 1ns/1ps
module scl_lane_select_bench;
   import scl_pkg::*;
   localparam int DW = 20;
   logic                         clk = 0;
   logic                         sys_rst = 1;
   scl_wb_req_type               wb_req = '0;
   scl_wb_rsp_type               wb_rsp;
   logic [3:0]                   pin = '0;
   logic [SCL_NPORT-1:0][DW-1:0] s_tx = '0, p_tx = '0, l_rx, l_tx, s_rx, p_rx;
   logic [SCL_NPORT-1:0]         s_en, p_en;
   logic [SCL_NPORT-1:0][1:0]    rate;
   logic [31:0]                  rd;
   logic [DW-1:0]                prv;
   int                           err_total = 0;
   int                           tests_run = 0;
   scl_lane_select i_dut (.clk(clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .lane_select_in_2(pin[0]), .lane_select_in_3(pin[1]), .lane_select_in_4(pin[2]), .lane_select_in_5(pin[3]),
      .sata_tx_data(s_tx), .pcie_tx_data(p_tx), .lane_rx_data(l_rx), .lane_tx_data(l_tx),
      .sata_rx_data(s_rx), .pcie_rx_data(p_rx), .sata_en(s_en), .pcie_en(p_en), .sata_rate(rate));
   scl_link_model i_link (.clk(clk), .sys_rst(sys_rst), .lane_rx_data(l_rx));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one classic cycle, entered and left just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
      do begin
         @(posedge clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         give_verdict();
      end
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      logic [11:0] st [3] = '{12'h2bd, 12'h9ff, 12'h000};
      logic [3:0] pv [3] = '{4'b0111, 4'b1010, 4'b1111};
      logic [3:0] mk [3] = '{4'b0101, 4'b0011, 4'b0000};
      for (int r = 0; r < 3; r++) begin
         @(posedge clk);
         sys_rst <= 1'b1;
         pin <= pv[r];
         for (int i = 0; i < SCL_NPORT; i++) begin
            s_tx[i] <= DW'(32'h5a000 + 16 * r + i);
            p_tx[i] <= DW'(32'ha5000 + 16 * r + i);
         end
         repeat (12) @(posedge clk);
         sys_rst <= 1'b0;
         @(posedge clk);
         wb(0, SCL_RATE_OFS, 0);
         chk("rate reset", rd, 32'haa);
         wb(0, 8'h40, 0);
         chk("unmapped", rd, 0);
         if (st[r] != 0) wb(1, SCL_STRAP_OFS, st[r]);
         wb(1, SCL_RATE_OFS, 32'h1b);
         wb(1, SCL_CTRL_OFS, 1);
         pin <= ~pv[r];
         wb(1, SCL_STRAP_OFS, 32'h155);
         for (int n = 0; n < 40 && (s_en | p_en) == 0; n++) @(posedge clk);
         chk("enables up", 32'(|(s_en | p_en)), 1);
         @(posedge clk);
         chk("sata en", s_en, mk[r]);
         chk("pcie en", p_en, 4'(~mk[r]));
         wb(0, SCL_STRAP_OFS, 0);
         chk("strap held", rd, st[r]);
         wb(0, SCL_STATUS_OFS, 0);
         chk("status", rd[5:0], {2'b01, mk[r]});
         chk("rate", rate, 8'h1a);
         for (int i = 0; i < SCL_NPORT; i++) begin
            chk("lane tx", l_tx[i], mk[r][i] ? s_tx[i] : p_tx[i]);
            @(posedge clk);
            #1 prv = l_rx[i];
            @(posedge clk);
            #1 chk("owner rx", mk[r][i] ? s_rx[i] : p_rx[i], prv);
            chk("idle rx", mk[r][i] ? p_rx[i] : s_rx[i], 0);
         end
         $display("round %0d done", r);
      end
      give_verdict();
   end
endmodule
